// *** core/phy_selfid_consts.vh ***
`ifndef PHY_SELFID_CONSTS_VH
`define PHY_SELFID_CONSTS_VH
// ****************************************
// register byte addresses
// ****************************************
`define ADDR_SPEED_CAP 8'h06
`define ADDR_SELFID_PARAM 8'h08
`define ADDR_EVENT_CTRL 8'h0a
// ****************************************
// speed capability fields
// ****************************************
`define SPEED_CODE 3'h2
`define REPEAT_DELAY 4'h0
// ****************************************
// self-id parameter fields and reset
// ****************************************
`define SID_LINK_BIT 7
`define SID_CONT_BIT 6
`define SID_JITTER 3'h0
`define SID_RESET 3'h0
`define SID_LINK_RESET 1'h1
`define SID_CONT_RESET 1'h1
// ****************************************
// event control bit positions
// ****************************************
`define EV_RESUME_BIT 7
`define EV_SHORT_BIT 6
`define EV_LOOP_BIT 5
`define EV_PWRFAIL_BIT 4
`define EV_TIMEOUT_BIT 3
`define EV_PORT_BIT 2
`define EV_ACCEL_BIT 1
`define EV_MULTI_BIT 0
// ****************************************
// bus responses
// ****************************************
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** core/phy_selfid_regs.v ***
// Notes on behaviour
// - speed bits 7-5 read constant 010, writes ignored
// - delay bits 3-0 and bit 4 read zero
// - bits 15-8 read zero, host writes zero
// - link-active bit sent in self-id at power-on
// - contender bit sent in self-id at power-on
// - jitter bits 5-3 read constant zero
// - power class bits 2-0 sent at power-on
// - cable power self-id forces link-active zero
// - cable power self-id forces contender zero
// - cable power self-id takes power class pins
// - resume sets port event only when enabled
// - short reset bit starts reset, self-clears
// - loop detection sets loop flag
// - supply failure sets power fail flag
// - arbitration timeout sets timeout flag
// - event flags clear only by writing one
// - port status change on a port with port_int_enable set, or enabled resume, sets port event
// - bit 1 enables arbitration acceleration
// - bit 0 enables multi-speed concatenation
//
// The AXI4-Lite interface to the registers was decided locally.
`include "phy_selfid_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module phy_selfid_regs #(
  parameter NUM_PORTS = 3
) (
  input wire clk_sys,
  input wire rst_b,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] supply_category_pins,
  input wire selfid_power_on,
  input wire selfid_cable_power,
  input wire loop_detect,
  input wire supply_fail,
  input wire arb_timeout,
  input wire resume_done,
  input wire [NUM_PORTS-1:0] port_status_change,
  input wire [NUM_PORTS-1:0] port_int_enable,
  input wire short_reset_done,
  output reg short_reset_request,
  output reg selfid_link_active,
  output reg selfid_contender,
  output reg [2:0] selfid_power_class,
  output reg arb_accel_enable,
  output reg multi_speed_enable
);
  // ****************************************
  // storage
  // ****************************************
  reg sid_link;
  reg sid_cont;
  reg [2:0] sid_pwr;
  reg resume_int;
  reg flag_loop;
  reg flag_pwrfail;
  reg flag_timeout;
  reg flag_port;
  reg [7:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  wire do_write;
  wire wr_ev;
  wire [7:0] wb;
  wire port_hit;
  reg [15:0] next_rdata;
  reg next_rerr;
  assign do_write = aw_have && w_have && !s_axi_bvalid;
  assign wb = w_data[7:0];
  assign wr_ev = do_write && (aw_addr == `ADDR_EVENT_CTRL) && w_strb[0];
  assign port_hit = |(port_status_change & port_int_enable);
  // ****************************************
  // write channel
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_addr <= 8'h00;
      aw_have <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      w_have <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `ADDR_SPEED_CAP || aw_addr == `ADDR_SELFID_PARAM ||
            aw_addr == `ADDR_EVENT_CTRL)
          s_axi_bresp <= `RESP_OKAY;
        else
          s_axi_bresp <= `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ****************************************
  // self-id parameters
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sid_link <= `SID_LINK_RESET;
      sid_cont <= `SID_CONT_RESET;
      sid_pwr <= `SID_RESET;
    end else if (do_write && aw_addr == `ADDR_SELFID_PARAM && w_strb[0]) begin
      sid_link <= wb[`SID_LINK_BIT];
      sid_cont <= wb[`SID_CONT_BIT];
      sid_pwr <= wb[2:0];
    end
  end
  // ****************************************
  // self-id packet fields
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      selfid_link_active <= 1'b0;
      selfid_contender <= 1'b0;
      selfid_power_class <= 3'h0;
    end else if (selfid_cable_power) begin
      selfid_link_active <= 1'b0;
      selfid_contender <= 1'b0;
      selfid_power_class <= supply_category_pins;
    end else if (selfid_power_on) begin
      selfid_link_active <= sid_link;
      selfid_contender <= sid_cont;
      selfid_power_class <= sid_pwr;
    end
  end
  // ****************************************
  // event control
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resume_int <= 1'b0;
      short_reset_request <= 1'b0;
      flag_loop <= 1'b0;
      flag_pwrfail <= 1'b0;
      flag_timeout <= 1'b0;
      flag_port <= 1'b0;
      arb_accel_enable <= 1'b0;
      multi_speed_enable <= 1'b0;
    end else begin
      if (wr_ev) begin
        resume_int <= wb[`EV_RESUME_BIT];
        arb_accel_enable <= wb[`EV_ACCEL_BIT];
        multi_speed_enable <= wb[`EV_MULTI_BIT];
      end
      if (short_reset_done)
        short_reset_request <= 1'b0;
      else if (wr_ev && wb[`EV_SHORT_BIT])
        short_reset_request <= 1'b1;
      // set wins over clear
      if (loop_detect)
        flag_loop <= 1'b1;
      else if (wr_ev && wb[`EV_LOOP_BIT])
        flag_loop <= 1'b0;
      if (supply_fail)
        flag_pwrfail <= 1'b1;
      else if (wr_ev && wb[`EV_PWRFAIL_BIT])
        flag_pwrfail <= 1'b0;
      if (arb_timeout)
        flag_timeout <= 1'b1;
      else if (wr_ev && wb[`EV_TIMEOUT_BIT])
        flag_timeout <= 1'b0;
      if (port_hit || (resume_done && resume_int))
        flag_port <= 1'b1;
      else if (wr_ev && wb[`EV_PORT_BIT])
        flag_port <= 1'b0;
    end
  end
  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    next_rdata = 16'h0000;
    next_rerr = 1'b0;
    if (s_axi_araddr == `ADDR_SPEED_CAP) begin
      next_rdata[7:5] = `SPEED_CODE;
      next_rdata[3:0] = `REPEAT_DELAY;
    end else if (s_axi_araddr == `ADDR_SELFID_PARAM) begin
      next_rdata[7:0] = {sid_link, sid_cont, `SID_JITTER, sid_pwr};
    end else if (s_axi_araddr == `ADDR_EVENT_CTRL) begin
      next_rdata[7:0] = {resume_int, short_reset_request, flag_loop,
        flag_pwrfail, flag_timeout, flag_port, arb_accel_enable,
        multi_speed_enable};
    end else begin
      next_rerr = 1'b1;
    end
  end
  // ****************************************
  // read channel
  // ****************************************
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, next_rdata};
        s_axi_rresp <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/phy_selfid_regs_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "phy_selfid_consts.vh"
// ***
// port checks
// ***
module phy_selfid_regs_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic [2:0] supply_category_pins,
  input wire logic selfid_cable_power,
  input wire logic short_reset_done,
  input wire logic short_reset_request,
  input wire logic selfid_link_active,
  input wire logic selfid_contender,
  input wire logic [2:0] selfid_power_class,
  input wire logic arb_accel_enable,
  input wire logic multi_speed_enable
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  sequence s_ar_speed;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `ADDR_SPEED_CAP;
  endsequence
  a_cable_link: assert property (selfid_cable_power |=> !selfid_link_active)
    else $error("link flag kept");
  a_cable_cont: assert property (selfid_cable_power |=> !selfid_contender)
    else $error("contender kept");
  a_cable_pins: assert property (selfid_cable_power |=>
    selfid_power_class == $past(supply_category_pins)) else $error("class");
  a_speed_word: assert property (s_ar_speed |=>
    s_axi_rvalid && s_axi_rdata == 32'h00000040) else $error("speed word");
  a_upper_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000) else $error("upper bits");
  a_done_clears: assert property (short_reset_done |=>
    !short_reset_request) else $error("request kept");
  a_request_holds: assert property (short_reset_request &&
    !short_reset_done |=> short_reset_request) else $error("request lost");
  a_enable_stable: assert property (!$rose(s_axi_bvalid) |->
    $stable({arb_accel_enable, multi_speed_enable})) else $error("enables");
endmodule
bind phy_selfid_regs phy_selfid_regs_props u_props (.*);
`default_nettype wire

// *** verif/reset_engine_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ***
// bus reset engine
// ***
module reset_engine_model #(
  parameter int DELAY = 5
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic short_reset_request,
  output logic short_reset_done
);
  int cnt;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      short_reset_done <= 1'b0;
    end else begin
      short_reset_done <= short_reset_request && cnt == DELAY;
      cnt <= (short_reset_request && cnt < DELAY) ? cnt + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// *** verif/phy_selfid_regs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "phy_selfid_consts.vh"
// ***
// register bench
// ***
module phy_selfid_regs_tb;
  logic clk_sys = '0, rst_b = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic s_axi_arvalid = '0, s_axi_bready = '1, s_axi_rready = '1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] supply_category_pins = '0, port_int_enable = '0;
  logic [8:0] p = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] selfid_power_class;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, short_reset_done, short_reset_request;
  logic selfid_link_active, selfid_contender, arb_accel_enable;
  logic multi_speed_enable;
  logic [31:0] sid_tab [2] = '{32'hc3, 32'h85};
  int n_fail = 0, cmp_count = 0, cyc = 0, i;
  localparam logic [7:0] ev = `ADDR_EVENT_CTRL, sid = `ADDR_SELFID_PARAM;
  phy_selfid_regs u_dut (.*, .selfid_power_on(p[0]),
    .selfid_cable_power(p[1]), .loop_detect(p[2]), .supply_fail(p[3]),
    .arb_timeout(p[4]), .resume_done(p[5]), .port_status_change(p[8:6]));
  reset_engine_model u_eng (.clk_sys, .rst_b, .short_reset_request,
    .short_reset_done);
  initial forever #10 clk_sys = ~clk_sys;
  task end_sim;
    $display("checks %0d fails %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      end_sim;
    end
  end
  task chk(input string n, input [31:0] s, input [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er = `RESP_OKAY);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (!s_axi_bvalid) @(posedge clk_sys);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task rdc(input string n, input [7:0] a, input [31:0] e,
    input [1:0] er = `RESP_OKAY);
    logic ar;
    ar = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!ar) begin
      @(posedge clk_sys);
      ar = s_axi_arready;
      s_axi_arvalid <= !ar;
    end
    while (!s_axi_rvalid) @(posedge clk_sys);
    chk(n, s_axi_rdata, e);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task pls(input [8:0] v);
    p <= v;
    repeat (3) @(posedge clk_sys);
    p <= 9'h000;
    repeat (2) @(posedge clk_sys);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rdc("sid", sid, 32'hc0);
    rdc("ev", ev, 32'h0);
    wr(`ADDR_SPEED_CAP, 32'hff);
    rdc("spd", `ADDR_SPEED_CAP, 32'h40);
    for (i = 0; i < 2; i++) begin
      wr(sid, sid_tab[i]);
      rdc("sid", sid, sid_tab[i]);
      supply_category_pins <= ~sid_tab[i][2:0];
      pls(9'h001);
      chk("out", {24'h0, selfid_link_active, selfid_contender, 3'h0,
        selfid_power_class}, sid_tab[i]);
      pls(9'h003);
      chk("cab", {24'h0, selfid_link_active, selfid_contender, 3'h0,
        selfid_power_class}, {29'h0, ~sid_tab[i][2:0]});
    end
    pls(9'h01c);
    rdc("ev", ev, 32'h38);
    wr(ev, 32'h10);
    rdc("ev", ev, 32'h28);
    port_int_enable <= 3'h2;
    pls(9'h068);
    rdc("ev", ev, 32'h38);
    wr(ev, 32'h38);
    port_int_enable <= 3'h3;
    pls(9'h040);
    rdc("ev", ev, 32'h04);
    wr(ev, 32'h84);
    pls(9'h020);
    rdc("ev", ev, 32'h84);
    wr(ev, 32'h07);
    rdc("ev", ev, 32'h03);
    wr(ev, 32'h41);
    chk("srq", {29'h0, short_reset_request, arb_accel_enable,
      multi_speed_enable}, 32'h5);
    while (short_reset_request) @(posedge clk_sys);
    rdc("ev", ev, 32'h01);
    wr(8'h0c, 32'h1, `RESP_SLVERR);
    rdc("un", 8'h0c, 32'h0, `RESP_SLVERR);
    end_sim;
  end
endmodule
`default_nettype wire
